// file: include/io_regs_pkg.sv
// Register map constants for the upper I/O register bank
// Assumes an 8-bit data-memory address and 4-bit data path
package io_regs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 4;
  // Offsets
  localparam logic [7:0] TIMER_IRQ_MASK_OFS = 8'heb;
  localparam logic [7:0] INPUT_IRQ_CAUSE_OFS = 8'hed;
  localparam logic [7:0] STOPWATCH_IRQ_CAUSE_OFS = 8'hee;
  localparam logic [7:0] TIMER_IRQ_CAUSE_OFS = 8'hef;
  localparam logic [7:0] OUTPUT_PORT_DATA_OFS = 8'hf3;
  localparam logic [7:0] BIDIR_PORT_DATA_OFS = 8'hf6;
  localparam logic [7:0] TIMER_STOPWATCH_CTRL_OFS = 8'hf9;
  localparam logic [7:0] LOAD_VOLTAGE_DETECT_OFS = 8'hfa;
  localparam logic [7:0] LCD_DRIVE_SELECT_OFS = 8'hfb;
  localparam logic [7:0] PORT_DIRECTION_OFS = 8'hfc;
  localparam logic [7:0] TONE_FREQ_SELECT_OFS = 8'hfd;
  // Field positions
  localparam int MASK_32HZ_BIT = 0;
  localparam int MASK_2HZ_BIT = 2;
  localparam int TICK_MASK_W = 3;
  localparam int SW_CAUSE_W = 2;
  localparam int FREQ_OUT_BIT = 0;
  localparam int BUZZER_BIT = 1;
  localparam int STOPWATCH_CLEAR_BIT = 0;
  localparam int STOPWATCH_RUN_BIT = 1;
  localparam int CLOCK_TIMER_CLEAR_BIT = 2;
  localparam int SUPPLY_DETECT_EN_BIT = 0;
  localparam int LOW_SUPPLY_BIT = 1;
  localparam int HEAVY_LOAD_BIT = 3;
  localparam int LCD_STATIC_BIT = 3;
  localparam int PORT_DIR_BIT = 0;
  localparam int FREQ_SEL_LO_BIT = 0;
  localparam int FREQ_SEL_HI_BIT = 1;
  localparam int BUZZER_TONE_BIT = 3;
  // Reset values
  localparam logic [2:0] TIMER_IRQ_MASK_RST = 3'h0;
  localparam logic [3:0] OUTPUT_PORT_DATA_RST = 4'h0;
  localparam logic [3:0] BIDIR_PORT_DATA_RST = 4'h0;
  localparam logic [1:0] FREQ_SEL_RST = 2'h0;
  localparam logic CTRL_BIT_RST = 1'b0;
endpackage

// file: include/cause_if.sv
// Carrier between the register bank and a bank of sticky cause flags
// Assumes set and clear come from the core clock domain
`timescale 1ns/1ps
interface cause_if #(parameter int W = 1);
  logic [W-1:0] set;
  logic clear;
  logic [W-1:0] flags;
  modport owner(output set, output clear, input flags);
  modport bank(input set, input clear, output flags);
endinterface

// file: src/cause_flags.sv
// Sticky cause flag bank, cleared as a whole
// Assumes synchronous set pulses and an already synchronised reset
`timescale 1ns/1ps
module cause_flags #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  cause_if.bank c
);
  initial begin
    if (W < 1 || W > 4) begin
      $error("cause_flags width out of range");
    end
  end

  // Set wins over clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c.flags <= '0;
    end else begin
      c.flags <= (c.flags & ~{W{c.clear}}) | c.set;
    end
  end
endmodule

// file: src/pin_sync.sv
// Three-stage input synchroniser with agreement filter
// Assumes asynchronous pin levels and a synchronised reset
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  initial begin
    if (W < 1) begin
      $error("pin_sync width must be positive");
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_o[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// file: src/io_control_register_bank.sv
// Upper I/O register bank: masks, cause flags, ports and control bits
// Assumes a one-cycle strobe register port on core_clk_i and same-clock event pulses
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module io_control_register_bank #(
  parameter bit BUZZER_OPTION = 1'b1,
  parameter bit FREQ_OUT_OPTION = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [3:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [3:0] rdata_o,
  input wire logic input_cause_event_i,
  input wire logic input_irq_enable_i,
  input wire logic [1:0] stopwatch_event_i,
  input wire logic [1:0] stopwatch_irq_mask_i,
  input wire logic [2:0] tick_event_i,
  input wire logic low_supply_i,
  input wire logic buzzer_wave_i,
  input wire logic freq_wave_i,
  output logic [3:0] output_pins_o,
  input wire logic [3:0] bidir_pins_i,
  output logic [3:0] bidir_pins_o,
  output logic bidir_pins_oe_n_o,
  output logic clock_timer_clear_o,
  output logic stopwatch_clear_o,
  output logic stopwatch_run_o,
  output logic heavy_load_mode_o,
  output logic supply_detect_enable_o,
  output logic lcd_static_select_o,
  output logic port_dir_out_o,
  output logic buzzer_tone_select_o,
  output logic [1:0] freq_select_o,
  output logic buzzer_enable_o,
  output logic freq_out_enable_o,
  output logic irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic wr_mask, wr_port, wr_bidir, wr_ctrl, wr_load, wr_lcd, wr_dir, wr_tone;
  logic rd_input, rd_sw, rd_tick;

  assign wr_mask = wr_i && addr_i == io_regs_pkg::TIMER_IRQ_MASK_OFS;
  assign wr_port = wr_i && addr_i == io_regs_pkg::OUTPUT_PORT_DATA_OFS;
  assign wr_bidir = wr_i && addr_i == io_regs_pkg::BIDIR_PORT_DATA_OFS;
  assign wr_ctrl = wr_i && addr_i == io_regs_pkg::TIMER_STOPWATCH_CTRL_OFS;
  assign wr_load = wr_i && addr_i == io_regs_pkg::LOAD_VOLTAGE_DETECT_OFS;
  assign wr_lcd = wr_i && addr_i == io_regs_pkg::LCD_DRIVE_SELECT_OFS;
  assign wr_dir = wr_i && addr_i == io_regs_pkg::PORT_DIRECTION_OFS;
  assign wr_tone = wr_i && addr_i == io_regs_pkg::TONE_FREQ_SELECT_OFS;
  assign rd_input = rd_i && addr_i == io_regs_pkg::INPUT_IRQ_CAUSE_OFS;
  assign rd_sw = rd_i && addr_i == io_regs_pkg::STOPWATCH_IRQ_CAUSE_OFS;
  assign rd_tick = rd_i && addr_i == io_regs_pkg::TIMER_IRQ_CAUSE_OFS;

  ////////////////////////////////////////////////////////////////////////////
  // Cause flags, cleared by reading them
  cause_if #(.W(1)) input_c ();
  cause_if #(.W(io_regs_pkg::SW_CAUSE_W)) sw_c ();
  cause_if #(.W(io_regs_pkg::TICK_MASK_W)) tick_c ();

  assign input_c.set = input_cause_event_i;
  assign input_c.clear = rd_input;
  assign sw_c.set = stopwatch_event_i;
  assign sw_c.clear = rd_sw;
  assign tick_c.set = tick_event_i;
  assign tick_c.clear = rd_tick;

  cause_flags #(.W(1)) u_input_cause (.clk_i(core_clk_i), .rst_n_i(rst_n), .c(input_c));
  cause_flags #(.W(io_regs_pkg::SW_CAUSE_W)) u_sw_cause (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .c(sw_c)
  );
  cause_flags #(.W(io_regs_pkg::TICK_MASK_W)) u_tick_cause (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .c(tick_c)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs
  logic low_supply_s;
  logic [3:0] bidir_s;

  pin_sync #(.W(1)) u_supply_sync (.clk_i(core_clk_i), .rst_n_i(rst_n), .pin_i(low_supply_i), .level_o(low_supply_s));
  pin_sync #(.W(4)) u_bidir_sync (.clk_i(core_clk_i), .rst_n_i(rst_n), .pin_i(bidir_pins_i), .level_o(bidir_s));

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  logic [2:0] tick_mask_q;
  logic [3:0] port_q;
  logic [3:0] bidir_q;
  logic sw_run_q, heavy_q, supply_en_q, lcd_static_q, dir_q, tone_q;
  logic [1:0] freq_sel_q;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_mask_q <= io_regs_pkg::TIMER_IRQ_MASK_RST;
    end else if (wr_mask) begin
      tick_mask_q <= wdata_i[io_regs_pkg::MASK_2HZ_BIT:io_regs_pkg::MASK_32HZ_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      port_q <= io_regs_pkg::OUTPUT_PORT_DATA_RST;
    end else if (wr_port) begin
      port_q <= wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bidir_q <= io_regs_pkg::BIDIR_PORT_DATA_RST;
    end else if (wr_bidir) begin
      bidir_q <= wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sw_run_q <= io_regs_pkg::CTRL_BIT_RST;
    end else if (wr_ctrl) begin
      sw_run_q <= wdata_i[io_regs_pkg::STOPWATCH_RUN_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      heavy_q <= io_regs_pkg::CTRL_BIT_RST;
      supply_en_q <= io_regs_pkg::CTRL_BIT_RST;
    end else if (wr_load) begin
      heavy_q <= wdata_i[io_regs_pkg::HEAVY_LOAD_BIT];
      supply_en_q <= wdata_i[io_regs_pkg::SUPPLY_DETECT_EN_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lcd_static_q <= io_regs_pkg::CTRL_BIT_RST;
    end else if (wr_lcd) begin
      lcd_static_q <= wdata_i[io_regs_pkg::LCD_STATIC_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= io_regs_pkg::CTRL_BIT_RST;
    end else if (wr_dir) begin
      dir_q <= wdata_i[io_regs_pkg::PORT_DIR_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tone_q <= io_regs_pkg::CTRL_BIT_RST;
      freq_sel_q <= io_regs_pkg::FREQ_SEL_RST;
    end else if (wr_tone) begin
      tone_q <= wdata_i[io_regs_pkg::BUZZER_TONE_BIT];
      freq_sel_q <= {wdata_i[io_regs_pkg::FREQ_SEL_HI_BIT], wdata_i[io_regs_pkg::FREQ_SEL_LO_BIT]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write-only clear pulses
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      clock_timer_clear_o <= 1'b0;
      stopwatch_clear_o <= 1'b0;
    end else begin
      clock_timer_clear_o <= wr_ctrl && wdata_i[io_regs_pkg::CLOCK_TIMER_CLEAR_BIT];
      stopwatch_clear_o <= wr_ctrl && wdata_i[io_regs_pkg::STOPWATCH_CLEAR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and control outputs
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      output_pins_o <= 4'h0;
      buzzer_enable_o <= 1'b0;
      freq_out_enable_o <= 1'b0;
    end else begin
      output_pins_o <= port_q;
      buzzer_enable_o <= BUZZER_OPTION && port_q[io_regs_pkg::BUZZER_BIT];
      freq_out_enable_o <= FREQ_OUT_OPTION && port_q[io_regs_pkg::FREQ_OUT_BIT];
      if (BUZZER_OPTION) begin
        output_pins_o[io_regs_pkg::BUZZER_BIT] <= port_q[io_regs_pkg::BUZZER_BIT] && buzzer_wave_i;
      end
      if (FREQ_OUT_OPTION) begin
        output_pins_o[io_regs_pkg::FREQ_OUT_BIT] <= port_q[io_regs_pkg::FREQ_OUT_BIT] && freq_wave_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bidir_pins_o <= 4'h0;
      bidir_pins_oe_n_o <= 1'b1;
    end else begin
      bidir_pins_o <= bidir_q;
      bidir_pins_oe_n_o <= !dir_q;
    end
  end

  assign stopwatch_run_o = sw_run_q;
  assign heavy_load_mode_o = heavy_q;
  assign supply_detect_enable_o = supply_en_q;
  assign lcd_static_select_o = lcd_static_q;
  assign port_dir_out_o = dir_q;
  assign buzzer_tone_select_o = tone_q;
  assign freq_select_o = freq_sel_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(tick_c.flags & tick_mask_q) || |(sw_c.flags & stopwatch_irq_mask_i) ||
               (input_c.flags[0] && input_irq_enable_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 4'h0;
    end else if (rd_i) begin
      unique case (addr_i)
        io_regs_pkg::TIMER_IRQ_MASK_OFS: rdata_o <= {1'b0, tick_mask_q};
        io_regs_pkg::INPUT_IRQ_CAUSE_OFS: rdata_o <= {3'h0, input_c.flags};
        io_regs_pkg::STOPWATCH_IRQ_CAUSE_OFS: rdata_o <= {2'h0, sw_c.flags};
        io_regs_pkg::TIMER_IRQ_CAUSE_OFS: rdata_o <= {1'b0, tick_c.flags};
        io_regs_pkg::OUTPUT_PORT_DATA_OFS: rdata_o <= port_q;
        io_regs_pkg::BIDIR_PORT_DATA_OFS: rdata_o <= dir_q ? bidir_q : bidir_s;
        io_regs_pkg::TIMER_STOPWATCH_CTRL_OFS: rdata_o <= {2'h0, sw_run_q, 1'b0};
        io_regs_pkg::LOAD_VOLTAGE_DETECT_OFS: rdata_o <= {heavy_q, 1'b0, low_supply_s, supply_en_q};
        io_regs_pkg::LCD_DRIVE_SELECT_OFS: rdata_o <= {lcd_static_q, 3'h0};
        io_regs_pkg::PORT_DIRECTION_OFS: rdata_o <= {3'h0, dir_q};
        io_regs_pkg::TONE_FREQ_SELECT_OFS: rdata_o <= {tone_q, 1'b0, freq_sel_q};
        default: rdata_o <= 4'h0;
      endcase
    end else begin
      rdata_o <= 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_ctrl_write(int b);
    wr_i && addr_i == io_regs_pkg::TIMER_STOPWATCH_CTRL_OFS && wdata_i[b];
  endsequence
  sequence s_single_pulse(logic p);
    p ##1 !p;
  endsequence

  a_mask_write_taken: assert property (wr_mask |=> tick_mask_q == $past(wdata_i[2:0]))
    else $error("tick mask not updated by write");
  a_input_cause_read: assert property (rd_input |=> rdata_o == {3'h0, $past(input_c.flags)})
    else $error("input cause read value wrong");
  a_sw_event_wins: assert property (stopwatch_event_i[0] && rd_sw |=> sw_c.flags[0])
    else $error("stopwatch cause lost on read clear");
  a_tick_cause_clear: assert property (rd_tick && tick_event_i == 3'h0 |=> tick_c.flags == 3'h0)
    else $error("tick cause not cleared by read");
  a_port_pin_follow: assert property (wr_port |=> ##1 output_pins_o[3:2] == $past(wdata_i[3:2], 2))
    else $error("output pins do not follow port data");
  a_buzzer_gated_off: assert property (!port_q[1] |=> !buzzer_enable_o)
    else $error("buzzer on while control bit clear");
  a_freq_out_follows: assert property (FREQ_OUT_OPTION && wr_port
      |=> ##1 freq_out_enable_o == $past(wdata_i[io_regs_pkg::FREQ_OUT_BIT], 2))
    else $error("frequency output enable wrong");
  a_dir_drives_pins: assert property (wr_dir |=> ##1 bidir_pins_oe_n_o == !$past(wdata_i[0], 2))
    else $error("port direction not applied");
  a_timer_clear_pulse: assert property (s_ctrl_write(io_regs_pkg::CLOCK_TIMER_CLEAR_BIT) ##1 !wr_ctrl
      |-> s_single_pulse(clock_timer_clear_o))
    else $error("clock timer clear not one pulse");
  a_sw_clear_pulse: assert property (s_ctrl_write(io_regs_pkg::STOPWATCH_CLEAR_BIT) ##1 !wr_ctrl
      |-> s_single_pulse(stopwatch_clear_o))
    else $error("stopwatch clear not one pulse");
  a_unmapped_reads_zero: assert property (rd_i && addr_i < io_regs_pkg::TIMER_IRQ_MASK_OFS
      |=> rdata_o == 4'h0)
    else $error("unmapped read not zero");
  a_irq_follows_cause: assert property (tick_c.flags[0] && tick_mask_q[0] |=> irq_o)
    else $error("interrupt missing for enabled cause");
  a_tick_cause_set: assert property (tick_event_i[0] |=> tick_c.flags[0])
    else $error("tick cause not set by event");
  a_read_idle_zero: assert property (!rd_i |=> rdata_o == 4'h0)
    else $error("read data not zero without strobe");
  a_bidir_drive_data: assert property (wr_bidir |=> ##1 bidir_pins_o == $past(wdata_i, 2))
    else $error("bidirectional drive data wrong");
  a_run_write_taken: assert property (wr_ctrl
      |=> stopwatch_run_o == $past(wdata_i[io_regs_pkg::STOPWATCH_RUN_BIT]))
    else $error("stopwatch run not updated by write");
  a_load_write_taken: assert property (wr_load
      |=> heavy_load_mode_o == $past(wdata_i[io_regs_pkg::HEAVY_LOAD_BIT])
        && supply_detect_enable_o == $past(wdata_i[io_regs_pkg::SUPPLY_DETECT_EN_BIT]))
    else $error("load and detect bits not updated by write");
  a_lcd_write_taken: assert property (wr_lcd
      |=> lcd_static_select_o == $past(wdata_i[io_regs_pkg::LCD_STATIC_BIT]))
    else $error("lcd drive select not updated by write");
  a_tone_write_taken: assert property (wr_tone
      |=> freq_select_o == $past(wdata_i[io_regs_pkg::FREQ_SEL_HI_BIT:io_regs_pkg::FREQ_SEL_LO_BIT])
        && buzzer_tone_select_o == $past(wdata_i[io_regs_pkg::BUZZER_TONE_BIT]))
    else $error("tone and frequency select not updated by write");
  a_detect_read_value: assert property (rd_i && addr_i == io_regs_pkg::LOAD_VOLTAGE_DETECT_OFS
      |=> rdata_o[2:1] == {1'b0, $past(low_supply_s)})
    else $error("detector result read wrong");
endmodule

// file: sim/tb.sv
// Self-checking bench for the upper I/O register bank
// Assumes the design carries its own assertions; the bench drives every port directly
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [3:0] wdata = 4'h0;
  logic wr = 1'b0, rd = 1'b0, in_ev = 1'b0, in_en = 1'b0, low_sup = 1'b0;
  logic bz_wave = 1'b1, fq_wave = 1'b1;
  logic [1:0] sw_ev = 2'h0, sw_mask = 2'h0, fsel;
  logic [2:0] tick_ev = 3'h0;
  logic [3:0] bd_in = 4'h0, rdata, pins, bd_out;
  logic bd_oe_n, tclr, sclr, sw_run, heavy, sd_en, lcd_st, pdir, bz_sel, bz_en, fq_en, irq;
  int n_mismatch = 0, n_checks = 0, tclr_cnt = 0, sclr_cnt = 0;
  logic [3:0] d;

  io_control_register_bank dut_u (.core_clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .input_cause_event_i(in_ev), .input_irq_enable_i(in_en),
    .stopwatch_event_i(sw_ev), .stopwatch_irq_mask_i(sw_mask), .tick_event_i(tick_ev),
    .low_supply_i(low_sup), .buzzer_wave_i(bz_wave), .freq_wave_i(fq_wave), .output_pins_o(pins),
    .bidir_pins_i(bd_in), .bidir_pins_o(bd_out), .bidir_pins_oe_n_o(bd_oe_n),
    .clock_timer_clear_o(tclr), .stopwatch_clear_o(sclr), .stopwatch_run_o(sw_run),
    .heavy_load_mode_o(heavy), .supply_detect_enable_o(sd_en), .lcd_static_select_o(lcd_st),
    .port_dir_out_o(pdir), .buzzer_tone_select_o(bz_sel), .freq_select_o(fsel),
    .buzzer_enable_o(bz_en), .freq_out_enable_o(fq_en), .irq_o(irq));

  initial begin
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    tclr_cnt += tclr;
    sclr_cnt += sclr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus and helper tasks
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [3:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [3:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic pulse_ev(input logic i, input logic [1:0] s, input logic [2:0] t);
    @(posedge clk);
    in_ev <= i;
    sw_ev <= s;
    tick_ev <= t;
    @(posedge clk);
    in_ev <= 1'b0;
    sw_ev <= 2'h0;
    tick_ev <= 3'h0;
    cycles(3);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    logic [7:0] a[10] = '{8'heb, 8'hed, 8'hee, 8'hef, 8'hf3, 8'hf6, 8'hfa, 8'hfb, 8'hfc, 8'hfd};
    foreach (a[k]) begin
      rd_reg(a[k], d);
      `CHK("reset_value", 4'h0, d)
    end
    rd_reg(8'hf9, d);
    `CHK("ctrl_reset", 4'h0, d & 4'ha)
    `CHK("oe_n_reset", 1'b1, bd_oe_n)
    `CHK("levels_reset", 8'h00, {sw_run, heavy, sd_en, lcd_st, pdir, bz_sel, fsel})
    `CHK("pins_reset", 4'h0, pins)
  endtask

  task automatic t_rw;
    logic [7:0] a[6] = '{8'heb, 8'hf3, 8'hfa, 8'hfb, 8'hfc, 8'hfd};
    logic [3:0] e[6] = '{4'h7, 4'hf, 4'h9, 4'h8, 4'h1, 4'hb};
    foreach (a[k]) wr_reg(a[k], 4'hf);
    wr_reg(8'hed, 4'hf);
    wr_reg(8'hf0, 4'hf);
    cycles(3);
    foreach (a[k]) begin
      rd_reg(a[k], d);
      `CHK("rw_ones", e[k], d)
    end
    rd_reg(8'hed, d);
    `CHK("ro_write", 4'h0, d)
    rd_reg(8'hf0, d);
    `CHK("unmapped", 4'h0, d)
    rd_reg(8'h10, d);
    `CHK("unmapped_low", 4'h0, d)
    `CHK("levels_set", 8'hff, {heavy, sd_en, lcd_st, pdir, bz_sel, fsel, bz_en})
    `CHK("pins_all", 4'hf, pins)
    `CHK("fq_en", 1'b1, fq_en)
    @(posedge clk);
    fq_wave <= 1'b0;
    cycles(3);
    `CHK("pin0_gated", 4'he, pins)
    @(posedge clk);
    bz_wave <= 1'b0;
    cycles(3);
    `CHK("pin1_gated", 4'hc, pins)
    for (int k = 0; k < 4; k++) begin
      wr_reg(8'hfd, 4'(k));
      cycles(3);
      `CHK("freq_select", 2'(k), fsel)
      `CHK("tone_select", 1'b0, bz_sel)
    end
    foreach (a[k]) wr_reg(a[k], 4'h0);
    cycles(3);
    `CHK("levels_clear", 6'h00, {heavy, sd_en, lcd_st, pdir, bz_en, fq_en})
    `CHK("pins_clear", 4'h0, pins)
    @(posedge clk);
    bz_wave <= 1'b1;
    fq_wave <= 1'b1;
  endtask

  task automatic t_ctrl;
    wr_reg(8'hf9, 4'ha);
    cycles(3);
    `CHK("sw_run", 1'b1, sw_run)
    rd_reg(8'hf9, d);
    `CHK("ctrl_read", 4'h2, d & 4'ha)
    tclr_cnt = 0;
    sclr_cnt = 0;
    wr_reg(8'hf9, 4'h4);
    cycles(4);
    `CHK("timer_clear", 2'd1, 2'(tclr_cnt))
    `CHK("sw_stop", 1'b0, sw_run)
    wr_reg(8'hf9, 4'h1);
    cycles(4);
    `CHK("sw_clear", 2'd1, 2'(sclr_cnt))
    wr_reg(8'hf9, 4'h0);
    cycles(4);
    `CHK("no_pulse", 4'h5, {2'(tclr_cnt), 2'(sclr_cnt)})
  endtask

  task automatic t_cause;
    for (int k = 0; k < 3; k++) begin
      wr_reg(8'heb, 4'(1 << k));
      pulse_ev(1'b0, 2'h0, 3'(1 << ((k + 1) % 3)));
      `CHK("irq_masked", 1'b0, irq)
      rd_reg(8'hef, d);
      `CHK("tick_flag_other", 4'(1 << ((k + 1) % 3)), d)
      pulse_ev(1'b0, 2'h0, 3'(1 << k));
      `CHK("irq_enabled", 1'b1, irq)
      rd_reg(8'hef, d);
      `CHK("tick_flag", 4'(1 << k), d)
      rd_reg(8'hef, d);
      `CHK("tick_cleared", 4'h0, d)
      cycles(3);
      `CHK("irq_dropped", 1'b0, irq)
    end
    wr_reg(8'heb, 4'h0);
    pulse_ev(1'b0, 2'h3, 3'h0);
    `CHK("sw_masked", 1'b0, irq)
    rd_reg(8'hee, d);
    `CHK("sw_flags", 4'h3, d)
    @(posedge clk);
    sw_mask <= 2'h2;
    pulse_ev(1'b0, 2'h2, 3'h0);
    `CHK("sw_irq", 1'b1, irq)
    rd_reg(8'hee, d);
    `CHK("sw_1hz", 4'h2, d)
    @(posedge clk);
    addr <= 8'hee;
    rd <= 1'b1;
    sw_ev <= 2'h1;
    sw_mask <= 2'h0;
    @(posedge clk);
    rd <= 1'b0;
    sw_ev <= 2'h0;
    in_en <= 1'b1;
    rd_reg(8'hee, d);
    `CHK("sw_set_wins", 4'h1, d)
    pulse_ev(1'b1, 2'h0, 3'h0);
    `CHK("in_irq", 1'b1, irq)
    rd_reg(8'hed, d);
    `CHK("in_flag", 4'h1, d)
    rd_reg(8'hed, d);
    `CHK("in_cleared", 4'h0, d)
    @(posedge clk);
    in_en <= 1'b0;
  endtask

  task automatic t_bidir;
    wr_reg(8'hfc, 4'h1);
    wr_reg(8'hf6, 4'ha);
    cycles(3);
    `CHK("oe_n_drive", 1'b0, bd_oe_n)
    `CHK("bidir_out", 4'ha, bd_out)
    rd_reg(8'hf6, d);
    `CHK("bidir_latch", 4'ha, d)
    @(posedge clk);
    bd_in <= 4'h5;
    wr_reg(8'hfc, 4'h0);
    cycles(6);
    `CHK("oe_n_input", 1'b1, bd_oe_n)
    rd_reg(8'hf6, d);
    `CHK("bidir_in", 4'h5, d)
  endtask

  task automatic t_supply;
    wr_reg(8'hfa, 4'h1);
    low_sup <= 1'b1;
    cycles(6);
    rd_reg(8'hfa, d);
    `CHK("low_supply", 4'h3, d)
    @(posedge clk);
    low_sup <= 1'b0;
    cycles(6);
    rd_reg(8'hfa, d);
    `CHK("supply_ok", 4'h1, d)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    cycles(4);
    t_reset();
    t_rw();
    t_ctrl();
    t_cause();
    t_bidir();
    t_supply();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("MISMATCH run_length expected done seen hang");
    complete_run();
  end
endmodule
